// ==== rtl/jtag_tap_pkg.sv ====
// Constants, instruction codes and TAP state encoding for the test access port
`default_nettype none

package jtag_tap_pkg;

  // ----------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------
  localparam int IR_W = 5;
  localparam logic [4:0] IR_CAPTURE = 5'h01;
  localparam logic [4:0] INS_IDCODE = 5'h01;
  localparam logic [4:0] INS_SAMPLE = 5'h02;
  localparam logic [4:0] INS_EXTEST = 5'h03;
  localparam logic [4:0] INS_RESET_HOLD = 5'h0C;
  localparam logic [4:0] INS_SERVICE_ADDR = 5'h10;
  localparam logic [4:0] INS_SERVICE_DATA = 5'h11;
  localparam logic [4:0] INS_BYPASS = 5'h1F;

  // ----------------------------------------------------------------
  // Data register lengths and field positions
  // ----------------------------------------------------------------
  localparam int ID_LEN = 32;
  localparam int BYPASS_LEN = 1;
  localparam int RESET_LEN = 1;
  localparam int SERVICE_ADDR_W = 36;
  localparam int SERVICE_DATA_W = 32;
  localparam int SERVICE_ADDR_LEN = SERVICE_ADDR_W + 1;
  localparam int SERVICE_DATA_LEN = SERVICE_DATA_W + 1;
  localparam int FLAG_POS = 0;

  // ----------------------------------------------------------------
  // Synchroniser depth and reset values
  // ----------------------------------------------------------------
  localparam int SYNC_STAGES = 2;
  localparam logic RESET_HOLD_INIT = 1'b0;
  localparam logic PINS_EN_INIT = 1'b0;

  // ----------------------------------------------------------------
  // TAP controller states
  // ----------------------------------------------------------------
  typedef enum logic [15:0] {
    TEST_LOGIC_RESET = 16'h0001,
    RUN_TEST_IDLE = 16'h0002,
    SELECT_DR = 16'h0004,
    CAPTURE_DR = 16'h0008,
    SHIFT_DR = 16'h0010,
    EXIT1_DR = 16'h0020,
    PAUSE_DR = 16'h0040,
    EXIT2_DR = 16'h0080,
    UPDATE_DR = 16'h0100,
    SELECT_IR = 16'h0200,
    CAPTURE_IR = 16'h0400,
    SHIFT_IR = 16'h0800,
    EXIT1_IR = 16'h1000,
    PAUSE_IR = 16'h2000,
    EXIT2_IR = 16'h4000,
    UPDATE_IR = 16'h8000
  } tap_state_e;

endpackage

`default_nettype wire

// ==== rtl/jtag_tap_controller.sv ====
// Test access port controller sampled from the system clock
`timescale 1ns/1ps
`default_nettype none

module jtag_tap_controller #(
  parameter int BSR_W = 16,
  parameter logic [31:0] ID_CODE = 32'h1234_5001 // Arbitrary identification value
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic extResetN,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdoOeN,
  output logic testPinsEnabled,
  output logic deviceResetHold,
  input wire logic [BSR_W-1:0] bsrIn,
  output logic [BSR_W-1:0] bsrOut,
  output logic extestActive,
  output logic [35:0] serviceAddr,
  output logic [31:0] serviceWrData,
  output logic serviceWrite,
  output logic serviceRequest,
  input wire logic serviceBusy,
  input wire logic [31:0] serviceRdData
);

  localparam int SHW = (BSR_W > jtag_tap_pkg::SERVICE_ADDR_LEN) ?
                       BSR_W : jtag_tap_pkg::SERVICE_ADDR_LEN;
  localparam int SS = jtag_tap_pkg::SYNC_STAGES;

  typedef struct packed {
    logic [SS:0] tckS;
    logic [SS-1:0] tmsS;
    logic [SS-1:0] tdiS;
    logic [SS:0] rstS;
    jtag_tap_pkg::tap_state_e st;
    logic [4:0] irSh;
    logic [4:0] ir;
    logic [SHW-1:0] drSh;
    logic tdo;
    logic tdoOeN;
    logic pinsEn;
    logic devRst;
    logic [BSR_W-1:0] bsrOut;
    logic extest;
    logic [35:0] addr;
    logic rdFlag;
    logic [31:0] wrData;
    logic wrFlag;
    logic req;
  } state_s;

  state_s q;
  state_s d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic jtag_tap_pkg::tap_state_e nextState(
    input jtag_tap_pkg::tap_state_e s,
    input logic m
  );
    case (s)
      jtag_tap_pkg::TEST_LOGIC_RESET:
        nextState = m ? jtag_tap_pkg::TEST_LOGIC_RESET : jtag_tap_pkg::RUN_TEST_IDLE;
      jtag_tap_pkg::RUN_TEST_IDLE:
        nextState = m ? jtag_tap_pkg::SELECT_DR : jtag_tap_pkg::RUN_TEST_IDLE;
      jtag_tap_pkg::SELECT_DR:
        nextState = m ? jtag_tap_pkg::SELECT_IR : jtag_tap_pkg::CAPTURE_DR;
      jtag_tap_pkg::CAPTURE_DR:
        nextState = m ? jtag_tap_pkg::EXIT1_DR : jtag_tap_pkg::SHIFT_DR;
      jtag_tap_pkg::SHIFT_DR:
        nextState = m ? jtag_tap_pkg::EXIT1_DR : jtag_tap_pkg::SHIFT_DR;
      jtag_tap_pkg::EXIT1_DR:
        nextState = m ? jtag_tap_pkg::UPDATE_DR : jtag_tap_pkg::PAUSE_DR;
      jtag_tap_pkg::PAUSE_DR:
        nextState = m ? jtag_tap_pkg::EXIT2_DR : jtag_tap_pkg::PAUSE_DR;
      jtag_tap_pkg::EXIT2_DR:
        nextState = m ? jtag_tap_pkg::UPDATE_DR : jtag_tap_pkg::SHIFT_DR;
      jtag_tap_pkg::UPDATE_DR:
        nextState = m ? jtag_tap_pkg::SELECT_DR : jtag_tap_pkg::RUN_TEST_IDLE;
      jtag_tap_pkg::SELECT_IR:
        nextState = m ? jtag_tap_pkg::TEST_LOGIC_RESET : jtag_tap_pkg::CAPTURE_IR;
      jtag_tap_pkg::CAPTURE_IR:
        nextState = m ? jtag_tap_pkg::EXIT1_IR : jtag_tap_pkg::SHIFT_IR;
      jtag_tap_pkg::SHIFT_IR:
        nextState = m ? jtag_tap_pkg::EXIT1_IR : jtag_tap_pkg::SHIFT_IR;
      jtag_tap_pkg::EXIT1_IR:
        nextState = m ? jtag_tap_pkg::UPDATE_IR : jtag_tap_pkg::PAUSE_IR;
      jtag_tap_pkg::PAUSE_IR:
        nextState = m ? jtag_tap_pkg::EXIT2_IR : jtag_tap_pkg::PAUSE_IR;
      jtag_tap_pkg::EXIT2_IR:
        nextState = m ? jtag_tap_pkg::UPDATE_IR : jtag_tap_pkg::SHIFT_IR;
      jtag_tap_pkg::UPDATE_IR:
        nextState = m ? jtag_tap_pkg::SELECT_DR : jtag_tap_pkg::RUN_TEST_IDLE;
      default:
        nextState = jtag_tap_pkg::TEST_LOGIC_RESET;
    endcase
  endfunction

  // Unknown codes fall back to the one-bit bypass path
  function automatic int drLen(input logic [4:0] ins);
    case (ins)
      jtag_tap_pkg::INS_IDCODE: drLen = jtag_tap_pkg::ID_LEN;
      jtag_tap_pkg::INS_SAMPLE: drLen = BSR_W;
      jtag_tap_pkg::INS_EXTEST: drLen = BSR_W;
      jtag_tap_pkg::INS_RESET_HOLD: drLen = jtag_tap_pkg::RESET_LEN;
      jtag_tap_pkg::INS_SERVICE_ADDR: drLen = jtag_tap_pkg::SERVICE_ADDR_LEN;
      jtag_tap_pkg::INS_SERVICE_DATA: drLen = jtag_tap_pkg::SERVICE_DATA_LEN;
      default: drLen = jtag_tap_pkg::BYPASS_LEN;
    endcase
  endfunction

  // Both boundary instructions share one chain
  function automatic logic isBoundary(input logic [4:0] ins);
    isBoundary = (ins == jtag_tap_pkg::INS_SAMPLE) || (ins == jtag_tap_pkg::INS_EXTEST);
  endfunction

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  // Edges come from the last two stages; the first may still be metastable
  function automatic logic riseOf(input logic [SS:0] s);
    riseOf = s[SS-1] & ~s[SS];
  endfunction

  function automatic logic fallOf(input logic [SS:0] s);
    fallOf = ~s[SS-1] & s[SS];
  endfunction

  // ----------------------------------------------------------------
  // Capture
  // ----------------------------------------------------------------
  // Parallel load for Capture-DR; bits above the selected length stay zero
  function automatic logic [SHW-1:0] captureWord(
    input logic [4:0] ins,
    input logic [BSR_W-1:0] pins,
    input logic hold,
    input logic [35:0] addr,
    input logic busy,
    input logic [31:0] rdData
  );
    case (ins)
      jtag_tap_pkg::INS_IDCODE: captureWord = SHW'(ID_CODE);
      jtag_tap_pkg::INS_SAMPLE: captureWord = SHW'(pins);
      jtag_tap_pkg::INS_EXTEST: captureWord = SHW'(pins);
      jtag_tap_pkg::INS_RESET_HOLD: captureWord = SHW'(hold);
      jtag_tap_pkg::INS_SERVICE_ADDR: captureWord = SHW'({addr, busy});
      jtag_tap_pkg::INS_SERVICE_DATA: captureWord = SHW'({rdData, busy});
      default: captureWord = '0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic tckRise;
  logic tckFall;
  logic rstRise;
  logic tmsV;
  logic tdiV;
  int len;

  always_comb
  begin
    d = q;
    len = drLen(q.ir);
    // Only the second stage of the mode and data synchronisers is looked at; clock and reset edges use the second and third
    d.tckS = {q.tckS[SS-1:0], tck};
    d.tmsS = {q.tmsS[SS-2:0], tms};
    d.tdiS = {q.tdiS[SS-2:0], tdi};
    d.rstS = {q.rstS[SS-1:0], extResetN};
    tckRise = riseOf(q.tckS);
    tckFall = fallOf(q.tckS);
    rstRise = riseOf(q.rstS);
    tmsV = q.tmsS[SS-1];
    tdiV = q.tdiS[SS-1];
    d.req = 1'b0;

    // Pin ownership decided once per reset release, from the synced clock level
    if (rstRise)
    begin
      d.pinsEn = ~q.tckS[SS-1];
    end

    // Disabled pins leave the controller parked in reset
    if (!q.pinsEn)
    begin
      d.st = jtag_tap_pkg::TEST_LOGIC_RESET;
      d.ir = jtag_tap_pkg::INS_IDCODE;
      d.tdoOeN = 1'b1;
    end
    else if (tckRise)
    begin
      d.st = nextState(q.st, tmsV);
      case (q.st)
        jtag_tap_pkg::TEST_LOGIC_RESET:
        begin
          d.ir = jtag_tap_pkg::INS_IDCODE;
          d.extest = 1'b0;
        end
        jtag_tap_pkg::CAPTURE_IR:
        begin
          d.irSh = jtag_tap_pkg::IR_CAPTURE;
        end
        jtag_tap_pkg::SHIFT_IR:
        begin
          d.irSh = {tdiV, q.irSh[4:1]};
        end
        jtag_tap_pkg::UPDATE_IR:
        begin
          d.ir = q.irSh;
          d.extest = (q.irSh == jtag_tap_pkg::INS_EXTEST);
        end
        jtag_tap_pkg::CAPTURE_DR:
        begin
          d.drSh = captureWord(q.ir, bsrIn, q.devRst, q.addr, serviceBusy,
                               serviceRdData);
        end
        jtag_tap_pkg::SHIFT_DR:
        begin
          // Fresh bit enters at the selected length so bit 0 always leads out
          d.drSh = q.drSh >> 1;
          d.drSh[len-1] = tdiV;
        end
        jtag_tap_pkg::UPDATE_DR:
        begin
          // Preload and external drive share one output latch
          if (isBoundary(q.ir))
          begin
            d.bsrOut = q.drSh[BSR_W-1:0];
          end
          case (q.ir)
            jtag_tap_pkg::INS_RESET_HOLD: d.devRst = q.drSh[0];
            jtag_tap_pkg::INS_SERVICE_ADDR:
            begin
              // A busy bus ignores the new address
              if (!serviceBusy)
              begin
                d.addr = q.drSh[jtag_tap_pkg::SERVICE_ADDR_W:1];
                d.rdFlag = q.drSh[jtag_tap_pkg::FLAG_POS];
                d.req = q.drSh[jtag_tap_pkg::FLAG_POS];
                d.wrFlag = 1'b0;
              end
            end
            jtag_tap_pkg::INS_SERVICE_DATA:
            begin
              // Write data lands only for a write-mode address and an idle bus
              if (!serviceBusy && !q.rdFlag)
              begin
                d.wrData = q.drSh[jtag_tap_pkg::SERVICE_DATA_W:1];
                d.wrFlag = 1'b1;
                d.req = 1'b1;
              end
            end
            default: d.devRst = q.devRst;
          endcase
        end
        default: d.irSh = q.irSh;
      endcase
    end
    else if (tckFall)
    begin
      // Output moves on the falling edge, half a test clock ahead of sampling
      if (q.st == jtag_tap_pkg::SHIFT_IR)
      begin
        d.tdo = q.irSh[0];
        d.tdoOeN = 1'b0;
      end
      else if (q.st == jtag_tap_pkg::SHIFT_DR)
      begin
        d.tdo = q.drSh[0];
        d.tdoOeN = 1'b0;
      end
      else
      begin
        d.tdoOeN = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      q <= '0;
      q.st <= jtag_tap_pkg::TEST_LOGIC_RESET;
      q.ir <= jtag_tap_pkg::INS_IDCODE;
      q.irSh <= jtag_tap_pkg::IR_CAPTURE;
      q.tdoOeN <= 1'b1;
      q.pinsEn <= jtag_tap_pkg::PINS_EN_INIT;
      q.devRst <= jtag_tap_pkg::RESET_HOLD_INIT;
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign tdo = q.tdo;
  assign tdoOeN = q.tdoOeN;
  assign testPinsEnabled = q.pinsEn;
  assign deviceResetHold = q.devRst;
  assign bsrOut = q.bsrOut;
  assign extestActive = q.extest;
  assign serviceAddr = q.addr;
  assign serviceWrData = q.wrData;
  assign serviceWrite = q.wrFlag;
  assign serviceRequest = q.req;

endmodule

`default_nettype wire

// ==== verification/jtag_tap_controller_sva.sv ====
// Concurrent checks on the test access port outputs
`timescale 1ns/1ps
`default_nettype none
module jtag_tap_controller_sva #(
  parameter int BSR_W = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic extResetN,
  input wire logic tck,
  input wire logic tdo,
  input wire logic tdoOeN,
  input wire logic testPinsEnabled,
  input wire logic deviceResetHold,
  input wire logic [BSR_W-1:0] bsrOut,
  input wire logic extestActive,
  input wire logic serviceRequest,
  input wire logic serviceBusy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ------------------------------------------------------------
  // Test clock phases as seen through the synchroniser
  // ------------------------------------------------------------
  sequence tckLow2;
    !$past(tck, 1) && !$past(tck, 2);
  endsequence
  sequence tckHigh2;
    $past(tck, 1) && $past(tck, 2);
  endsequence
  // Reset pin rise and clock level as the enable decision saw them
  sequence pinsRelease;
    $past(extResetN, 3) && !$past(extResetN, 4) && !$past(tck, 3);
  endsequence
  chk_reset_idle: assert property ($fell(reset) |-> tdoOeN && !testPinsEnabled)
    else $error("outputs not idle after reset");
  chk_pins_rise: assert property ($rose(testPinsEnabled) |-> pinsRelease)
    else $error("pins enabled without reset release at low test clock");
  chk_oe_gated: assert property (!testPinsEnabled ##1 !testPinsEnabled |-> tdoOeN)
    else $error("serial output driven while pins disabled");
  chk_oe_fall: assert property ($changed(tdoOeN) |-> tckLow2)
    else $error("output enable moved outside low test clock");
  chk_tdo_fall: assert property ($changed(tdo) |-> tckLow2)
    else $error("serial output moved outside low test clock");
  chk_oe_hold: assert property ($fell(tdoOeN) |=> !tdoOeN [*6])
    else $error("output enable shorter than one test clock");
  chk_req_pulse: assert property (serviceRequest |=> !serviceRequest)
    else $error("service request longer than one cycle");
  chk_req_busy: assert property (serviceRequest |-> !$past(serviceBusy, 1))
    else $error("service request while busy");
  chk_bsr_rise: assert property ($changed(bsrOut) |-> tckHigh2)
    else $error("boundary latch moved outside high test clock");
  chk_ir_rise: assert property ($changed(extestActive) || $changed(deviceResetHold) |-> tckHigh2)
    else $error("instruction effect moved outside high test clock");
endmodule
bind jtag_tap_controller jtag_tap_controller_sva #(.BSR_W(BSR_W)) jtag_tap_controller_sva_inst (
  .clk, .reset, .extResetN, .tck, .tdo, .tdoOeN, .testPinsEnabled, .deviceResetHold,
  .bsrOut, .extestActive, .serviceRequest, .serviceBusy);
`default_nettype wire

// ==== verification/jtag_debugger_model.sv ====
// Behavioural debugger driving test clock, mode select and data input
`timescale 1ns/1ps
`default_nettype none
module jtag_debugger_model (
  input wire logic clk,
  input wire logic tdo,
  input wire logic tdoOeN,
  output logic tck,
  output logic tms,
  output logic tdi
);
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // Inputs move in the low phase; output read late in the high phase
  task automatic step(input logic ms, input logic di, output logic dout, output logic oeN);
    tms <= ms;
    tdi <= di;
    repeat (4) @(posedge clk);
    tck <= 1'b1;
    repeat (4) @(posedge clk);
    dout = tdo;
    oeN = tdoOeN;
    tck <= 1'b0;
  endtask
  // Level held while the reset pin is released
  task automatic park(input logic level);
    @(posedge clk);
    tck <= level;
  endtask
  task automatic scan(input logic isIr, input logic [63:0] din, input int len,
                      output logic [63:0] dout, output logic oeBad);
    logic d;
    logic oe;
    dout = '0;
    oeBad = 1'b0;
    step(1'b1, 1'b0, d, oe);
    if (isIr)
      step(1'b1, 1'b0, d, oe);
    step(1'b0, 1'b0, d, oe);
    step(1'b0, 1'b0, d, oe);
    for (int i = 0; i < len; i++)
    begin
      step(i == len - 1, din[i], d, oe);
      dout[i] = d;
      oeBad |= oe;
    end
    step(1'b1, 1'b0, d, oe);
    step(1'b0, 1'b0, d, oe);
  endtask
endmodule
`default_nettype wire

// ==== verification/jtag_tap_controller_tb.sv ====
// Self-checking bench for the test access port controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) compare(64'(got), 64'(exp))
module jtag_tap_controller_tb;
  localparam int BW = 16;
  localparam logic [31:0] IDV = 32'h1234_5001; // Arbitrary identification value
  localparam logic [11:0] WALK = 12'b0111_1100_1001;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic extResetN = 1'b0;
  logic tck, tms, tdi, tdo, tdoOeN, testPinsEnabled, deviceResetHold, extestActive;
  logic serviceWrite, serviceRequest, d, oe, oeBad;
  logic serviceBusy = 1'b0;
  logic [BW-1:0] bsrIn = '0;
  logic [BW-1:0] bsrOut;
  logic [35:0] serviceAddr;
  logic [31:0] serviceWrData;
  logic [31:0] serviceRdData = '0;
  logic [63:0] dout, din;
  int bad_count = 0;
  int n_compared = 0;
  int reqCount = 0;
  always #10 clk = ~clk;
  always @(posedge clk)
    if (serviceRequest === 1'b1)
      reqCount++;
  jtag_tap_controller #(.BSR_W(BW), .ID_CODE(IDV)) jtag_tap_controller_inst (
    .clk, .reset, .extResetN, .tck, .tms, .tdi, .tdo, .tdoOeN, .testPinsEnabled,
    .deviceResetHold, .bsrIn, .bsrOut, .extestActive, .serviceAddr, .serviceWrData,
    .serviceWrite, .serviceRequest, .serviceBusy, .serviceRdData);
  jtag_debugger_model jtag_debugger_model_inst (.clk, .tdo, .tdoOeN, .tck, .tms, .tdi);
  task automatic compare(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic shift(input logic isIr, input logic [63:0] v, input int len);
    jtag_debugger_model_inst.scan(isIr, v, len, dout, oeBad);
    repeat (4) @(posedge clk);
  endtask
  function automatic logic [63:0] bypassOut(input logic [63:0] v, input int len);
    return (v << 1) & ((64'h1 << len) - 1);
  endfunction
  initial
  begin
    void'($urandom(32'h7790_ca05));
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    extResetN <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK(testPinsEnabled, 1'b1);
    `CHK(tdoOeN, 1'b1);
    for (int i = 0; i < 6; i++)
      jtag_debugger_model_inst.step(i < 5, 1'b0, d, oe);
    din = {$urandom, $urandom};
    shift(1'b0, din, 32);
    `CHK(dout[31:0], IDV);
    `CHK(oeBad, 1'b0);
    $display("test idcode done");
    shift(1'b1, jtag_tap_pkg::INS_BYPASS, 5);
    `CHK(dout[4:0], jtag_tap_pkg::IR_CAPTURE);
    din = $urandom;
    shift(1'b0, din, 8);
    `CHK(dout, bypassOut(din, 8));
    $display("test bypass done");
    bsrIn <= BW'($urandom);
    din = $urandom;
    shift(1'b1, jtag_tap_pkg::INS_SAMPLE, 5);
    shift(1'b0, din, BW);
    `CHK(dout[BW-1:0], bsrIn);
    `CHK(bsrOut, din[BW-1:0]);
    shift(1'b1, jtag_tap_pkg::INS_EXTEST, 5);
    `CHK(extestActive, 1'b1);
    shift(1'b1, jtag_tap_pkg::INS_RESET_HOLD, 5);
    `CHK(extestActive, 1'b0);
    shift(1'b0, 64'h1, 1);
    `CHK(deviceResetHold, 1'b1);
    shift(1'b0, 64'h0, 1);
    `CHK(deviceResetHold, 1'b0);
    $display("test boundary and hold done");
    serviceBusy <= 1'b1;
    din = {$urandom, $urandom} | 64'h1;
    shift(1'b1, jtag_tap_pkg::INS_SERVICE_ADDR, 5);
    shift(1'b0, din, 37);
    `CHK(dout[0], 1'b1);
    `CHK(reqCount, 0);
    serviceBusy <= 1'b0;
    shift(1'b0, din, 37);
    `CHK(dout[0], 1'b0);
    `CHK(serviceAddr, din[36:1]);
    `CHK({reqCount[1:0], serviceWrite}, 3'b010);
    shift(1'b0, din & ~64'h1, 37);
    serviceRdData <= $urandom;
    din = {$urandom, $urandom};
    shift(1'b1, jtag_tap_pkg::INS_SERVICE_DATA, 5);
    shift(1'b0, din, 33);
    `CHK(dout[32:1], serviceRdData);
    `CHK(serviceWrData, din[32:1]);
    `CHK({reqCount[1:0], serviceWrite}, 3'b101);
    $display("test service access done");
    shift(1'b1, jtag_tap_pkg::INS_EXTEST, 5);
    for (int i = 0; i < 12; i++)
    begin
      jtag_debugger_model_inst.step(WALK[i], 1'b1, d, oe);
      if (i == 5)
        `CHK(oe, 1'b1);
    end
    `CHK(extestActive, 1'b0);
    shift(1'b0, 64'h0, 32);
    `CHK(dout[31:0], IDV);
    $display("test pause and reset walk done");
    jtag_debugger_model_inst.park(1'b1);
    extResetN <= 1'b0;
    repeat (8) @(posedge clk);
    extResetN <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK(testPinsEnabled, 1'b0);
    `CHK(tdoOeN, 1'b1);
    $display("test pin disable done");
    tally_and_finish();
  end
  initial
  begin
    repeat (40000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
